// >>> hw/disk_fault_consts.svh
// constants for the disk control fault and status block
`ifndef DISK_FAULT_CONSTS_SVH
`define DISK_FAULT_CONSTS_SVH
`define CLK_MHZ            125
`define NEM_TIMEOUT_US     20
`define NEM_TIMEOUT_CYC    (`NEM_TIMEOUT_US * `CLK_MHZ)
`define MXF_REVS           3
`define REV_CYC_DEFAULT    32'h0000_1000
`define UNIT_OVERFLOW_NUM  4'h8
`define PTR_STEP           16'h0002
`define FN_WRITE           2'h1
`define FN_CHECK           2'h3
`define FN_READ            2'h2
`define FN_NOP             2'h0
`define INTR_LEVEL         3'h5
`define REG_CTRL           4'h0
`define REG_STATUS         4'h4
`define REG_FAULT          4'h8
`define REG_POINTER        4'hC
`define REG_COUNT          5'h10
`define CTRL_GO_BIT        0
`define CTRL_FN_LO         1
`define CTRL_IA_BIT        3
`define CTRL_SL_BIT        4
`define CTRL_MA_BIT        5
`define CTRL_CLR_BIT       8
`define CTRL_UNIT_LO       12
`endif

// >>> hw/disk_fault_pkg.sv
// types shared by the disk control fault and status block
package disk_fault_pkg;
  typedef struct packed {
    logic parity_bad;    // data word parity mismatch
    logic bits_bad;      // data word bit count wrong
    logic compare_bad;   // write check mismatch
    logic addr_par_bad;  // surface address parity mismatch
    logic prim_neg_bad;  // primary track missing neg / extra pos
    logic prim_pos_bad;  // primary track missing pos / extra neg
    logic second_bad;    // second track pulse error
    logic third_bad;     // third track pulse error
    logic word_done;     // one word moved
    logic word_ready;    // new word ready to move
    logic word_taken;    // previous word taken
    logic rev_mark;      // once per revolution index
  } disk_event_type;
  typedef enum logic [1:0] {
    st_idle,
    st_run,
    st_frozen
  } ctl_state_type;
endpackage

// >>> hw/disk_control_fault_status.sv
// fault, status and transfer bookkeeping of a fixed-head disk control
//
// Decided for this implementation: register access over Avalon-MM and the register addresses.
`timescale 1ns/10ps
`include "disk_fault_consts.svh"
module disk_control_fault_status
  import disk_fault_pkg::*;
#(
  parameter int          REV_CYC     = `REV_CYC_DEFAULT, // cycles per rev
  parameter int          NEM_CYC     = `NEM_TIMEOUT_CYC, // slave sync limit
  parameter logic [7:0]  UNITS_FITTED = 8'h01            // installed units
) (
  input  wire logic           clk_i,          // 125 MHz clock
  input  wire logic           nrst_i,         // async reset, low
  input  wire logic           init_i,         // processor initialize
  input  wire logic [4:0]     avs_address_i,  // byte address
  input  wire logic           avs_read_i,     // read request
  input  wire logic           avs_write_i,    // write request
  input  wire logic [31:0]    avs_writedata_i,// write data
  input  wire logic [3:0]     avs_byteenable_i,// byte lanes
  output logic [31:0]         avs_readdata_o, // read data
  output logic                avs_waitrequest_o,// stall
  input  wire disk_event_type ev_i,           // disk side events
  input  wire logic           protect_i,      // area protect switch on
  input  wire logic           advance_i,      // auto advance to next unit
  input  wire logic           slave_sync_i,   // bus slave sync (pin)
  output logic                bus_request_o,  // memory request pending
  output logic [15:0]         bus_address_o,  // memory pointer out
  output logic                soft_fault_o,   // summary without freeze
  output logic                disk_flag_o,    // fault or ready
  output logic                data_flag_o,    // memory request flag
  output logic                intr_o,         // interrupt request
  output logic [2:0]          intr_level_o,   // request priority
  output logic                ready_o,        // control ready
  output logic                write_drive_o,  // writers enabled
  output logic                run_o,          // transfer in progress
  output logic                timing_on_o     // disk timing enabled
);

  ctl_state_type state_q;          // control state
  logic [1:0]    fn_q;             // function code
  logic          allow_q;          // interrupt allow
  logic          single_q;         // single location mode
  logic          maint_q;          // maintenance mode
  logic [3:0]    unit_q;           // selected unit
  logic [15:0]   ptr_q;            // memory pointer
  logic [15:0]   count_q;          // word count, counts to zero
  logic          par_q, bits_q, cmp_q, absent_q, prot_q, mxf_q;
  logic          chain_q, psel_q, ovf_q, late_q, blk_q;
  logic          ape_q, mn_q, mp_q, bt_q, ct_q, nem_q;
  logic [1:0]    rev_cnt_q;        // revolutions without a transfer
  logic [31:0]   nem_cnt_q;        // slave sync wait counter
  logic [2:0]    sync_q;           // slave sync synchroniser
  logic          sync_lvl_q;       // filtered slave sync
  logic          rd_pend_q;        // read answer on next cycle
  logic [31:0]   rdata_q;          // registered read data

  wire wr_ctrl  = avs_write_i && avs_address_i == `REG_CTRL &&
                  avs_byteenable_i[1:0] == 2'h3;
  wire wr_ptr   = avs_write_i && avs_address_i == `REG_POINTER;
  wire wr_cnt   = avs_write_i && avs_address_i == `REG_COUNT;
  wire clr      = init_i || (wr_ctrl && avs_writedata_i[`CTRL_CLR_BIT]);
  wire go       = wr_ctrl && avs_writedata_i[`CTRL_GO_BIT] && !clr;
  wire [1:0] fn_w = avs_writedata_i[`CTRL_FN_LO +: 2];
  wire [3:0] unit_w = avs_writedata_i[`CTRL_UNIT_LO +: 4];
  // freeze gathers the hard faults
  wire freeze   = ape_q | mn_q | mp_q | bt_q | ct_q | nem_q;
  // summary gathers soft faults plus freeze
  wire summary  = freeze | par_q | bits_q | cmp_q | absent_q | prot_q |
                  mxf_q;
  wire busy     = state_q == st_run;
  wire active   = busy && !freeze;
  wire writing  = active && (fn_q == `FN_WRITE);
  wire [3:0] next_unit = unit_q + 4'h1;
  wire sync_now = sync_q[2] & sync_q[1];  // second and third agree

  function automatic logic fitted(input logic [3:0] u);
    fitted = !u[3] && UNITS_FITTED[u[2:0]];
  endfunction

  // control state: go starts, faults or block end stop, freeze holds
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_q <= st_idle;
    end else if (clr) begin
      state_q <= st_idle;
    end else if (freeze) begin
      state_q <= st_frozen;
    end else if (busy && (summary || blk_q)) begin
      state_q <= st_idle;                             // soft fault ends it
    end else if (go && fn_w != `FN_NOP && fitted(unit_q)) begin
      state_q <= st_run;
    end
  end

  // software control fields; function is kept for resuming
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      fn_q     <= `FN_NOP;
      allow_q  <= 1'b0;
      single_q <= 1'b0;
      maint_q  <= 1'b0;
      unit_q   <= 4'h0;
    end else if (clr) begin
      fn_q     <= `FN_NOP;
      allow_q  <= 1'b0;
      single_q <= 1'b0;
      maint_q  <= 1'b0;
      unit_q   <= 4'h0;
    end else if (wr_ctrl) begin
      fn_q     <= fn_w;
      allow_q  <= avs_writedata_i[`CTRL_IA_BIT];
      single_q <= avs_writedata_i[`CTRL_SL_BIT];
      maint_q  <= avs_writedata_i[`CTRL_MA_BIT];
      unit_q   <= unit_w;
    end else if (active && advance_i) begin
      unit_q   <= next_unit;
    end
  end

  // pointer and word count; the address bus takes the pointer only when a request is raised
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ptr_q   <= 16'h0000;
      count_q <= 16'h0000;
    end else begin
      if (wr_ptr) begin
        ptr_q <= avs_writedata_i[15:0];
      end else if (active && ev_i.word_done && !single_q) begin
        ptr_q <= ptr_q + `PTR_STEP;
      end
      if (wr_cnt) begin
        count_q <= avs_writedata_i[15:0];
      end else if (active && ev_i.word_done && count_q != 16'h0000) begin
        count_q <= count_q - 16'h0001;
      end
    end
  end

  // soft faults, sticky; set wins over a go clear
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      {par_q, bits_q, cmp_q, absent_q, prot_q, mxf_q} <= 6'h00;
      {chain_q, psel_q, ovf_q, blk_q}                  <= 4'h0;
    end else if (clr) begin
      {par_q, bits_q, cmp_q, absent_q, prot_q, mxf_q} <= 6'h00;
      {chain_q, psel_q, ovf_q, blk_q}                  <= 4'h0;
    end else begin
      par_q    <= (par_q && !go) || (active && ev_i.parity_bad);
      bits_q   <= (bits_q && !go) || (active && ev_i.bits_bad);
      cmp_q    <= (cmp_q && !go) ||
                  (active && fn_q == `FN_CHECK && ev_i.compare_bad);
      prot_q   <= (prot_q && !go) || (writing && protect_i);
      mxf_q    <= (mxf_q && !go) ||
                  (active && ev_i.rev_mark &&
                   rev_cnt_q == 2'(`MXF_REVS - 1) && !ev_i.word_done);
      chain_q  <= chain_q || (active && advance_i &&
                  !fitted(next_unit));
      psel_q   <= psel_q || (wr_ctrl && !fitted(unit_w));
      ovf_q    <= ovf_q || (active && advance_i &&
                  next_unit == `UNIT_OVERFLOW_NUM);
      absent_q <= (absent_q && !(wr_ctrl && fitted(unit_w))) ||
                  (wr_ctrl && !fitted(unit_w)) ||
                  (active && advance_i && !fitted(next_unit));
      blk_q    <= (blk_q && !go) || (active && ev_i.word_done &&
                  count_q == 16'h0001);
    end
  end

  // late request is a status only and never stops the function
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      late_q <= 1'b0;
    end else if (clr) begin
      late_q <= 1'b0;
    end else begin
      late_q <= (late_q && !go) ||
                (active && ev_i.word_ready && !ev_i.word_taken);
    end
  end

  // hard faults; only initialize or disk clear removes them
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      {ape_q, mn_q, mp_q, bt_q, ct_q, nem_q} <= 6'h00;
    end else if (clr) begin
      {ape_q, mn_q, mp_q, bt_q, ct_q, nem_q} <= 6'h00;
    end else begin
      ape_q <= ape_q || (busy && ev_i.addr_par_bad);
      mn_q  <= mn_q  || (busy && ev_i.prim_neg_bad);
      mp_q  <= mp_q  || (busy && ev_i.prim_pos_bad);
      bt_q  <= bt_q  || (busy && ev_i.second_bad);
      ct_q  <= ct_q  || (busy && ev_i.third_bad);
      nem_q <= nem_q || (bus_request_o &&
               nem_cnt_q >= 32'(NEM_CYC - 1) && !sync_lvl_q);
    end
  end

  // revolution counter: reset by each moved word
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rev_cnt_q <= 2'h0;
    end else if (!active || ev_i.word_done) begin
      rev_cnt_q <= 2'h0;
    end else if (ev_i.rev_mark && rev_cnt_q != 2'h3) begin
      rev_cnt_q <= rev_cnt_q + 2'h1;
    end
  end

  // slave sync pin passes three flops; change counts when 2 and 3 agree
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sync_q     <= 3'h0;
      sync_lvl_q <= 1'b0;
    end else begin
      sync_q <= {sync_q[1:0], slave_sync_i};
      if (sync_q[2] == sync_q[1]) begin
        sync_lvl_q <= sync_now;
      end
    end
  end

  // memory request: raised per word ready, dropped on sync or timeout
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      bus_request_o <= 1'b0;
      nem_cnt_q     <= 32'h0;
      bus_address_o <= 16'h0000;
    end else if (clr || freeze || sync_lvl_q) begin
      bus_request_o <= 1'b0;
      nem_cnt_q     <= 32'h0;
    end else if (bus_request_o) begin
      nem_cnt_q <= nem_cnt_q + 32'h1;
    end else if (active && ev_i.word_ready) begin
      bus_request_o <= 1'b1;
      bus_address_o <= ptr_q;
      nem_cnt_q     <= 32'h0;
    end
  end

  // bus slave: one wait cycle, then registered read data
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rd_pend_q <= 1'b0;
      rdata_q   <= 32'h0;
    end else begin
      rd_pend_q <= avs_read_i && !rd_pend_q;
      case (avs_address_i)
        `REG_CTRL:    rdata_q <= {16'h0, unit_q, 2'h0, summary, freeze,
                                  ready_o, 1'b0, maint_q, single_q,
                                  allow_q, fn_q, 1'b0};
        `REG_STATUS:  rdata_q <= {20'h0, soft_fault_o, late_q, blk_q,
                                  ovf_q, chain_q, psel_q, absent_q,
                                  mxf_q, prot_q, cmp_q, bits_q, par_q};
        `REG_FAULT:   rdata_q <= {26'h0, nem_q, ct_q, bt_q, mp_q, mn_q,
                                  ape_q};
        `REG_POINTER: rdata_q <= {16'h0, ptr_q};
        `REG_COUNT:   rdata_q <= {16'h0, count_q};
        default:      rdata_q <= 32'h0;   // unmapped reads as zero
      endcase
    end
  end

  // writes complete at once; reads wait one cycle for the data flop
  assign avs_waitrequest_o = avs_read_i && !rd_pend_q;
  assign avs_readdata_o    = rdata_q;
  assign soft_fault_o      = summary && !freeze;
  assign disk_flag_o       = summary || ready_o;
  assign intr_o            = disk_flag_o && allow_q;
  assign intr_level_o      = `INTR_LEVEL;
  assign data_flag_o       = bus_request_o;
  assign ready_o           = !busy;
  assign write_drive_o     = writing;
  assign run_o             = active;
  assign timing_on_o       = !freeze;

endmodule // disk_control_fault_status

// >>> tb/disk_fault_asserts.sv
// port-level checks on the disk control fault and status block
`timescale 1ns/10ps
module disk_fault_asserts
  import disk_fault_pkg::*;
#(
  parameter int NEM_CYC = 2500 // slave sync limit in cycles
) (
  input wire logic       clk_i,         // block clock
  input wire logic       nrst_i,        // async reset, low
  input wire logic       init_i,        // processor initialize
  input wire logic       avs_write_i,   // register write request
  input wire logic       bus_request_o, // memory request pending
  input wire logic       soft_fault_o,  // summary without freeze
  input wire logic       disk_flag_o,   // fault or ready
  input wire logic       data_flag_o,   // memory request flag
  input wire logic       intr_o,        // interrupt request
  input wire logic [2:0] intr_level_o,  // request priority
  input wire logic       ready_o,       // control ready
  input wire logic       write_drive_o, // writers enabled
  input wire logic       run_o,         // transfer in progress
  input wire logic       timing_on_o    // disk timing enabled
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  logic [15:0] pend_q; // cycles the memory request has waited
  // saturating wait counter, so a stuck request never wraps back
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) pend_q <= 16'h0000;
    else if (!bus_request_o) pend_q <= 16'h0000;
    else if (pend_q != 16'hFFFF) pend_q <= pend_q + 16'h0001;
  end
  chk_ready_busy: assert property (run_o |-> !ready_o)
    else $error("ready seen during a transfer");
  chk_level_five: assert property (intr_level_o == 3'h5)
    else $error("interrupt level is not five");
  chk_intr_flag: assert property (intr_o |-> disk_flag_o)
    else $error("interrupt without disk flag");
  chk_ready_flag: assert property (ready_o |-> disk_flag_o)
    else $error("ready without disk flag");
  chk_fault_flag: assert property (soft_fault_o |-> disk_flag_o)
    else $error("fault without disk flag");
  chk_data_req: assert property (data_flag_o == bus_request_o)
    else $error("data flag differs from memory request");
  chk_write_run: assert property (write_drive_o |-> run_o)
    else $error("writers on outside a transfer");
  chk_freeze_stop: assert property (!timing_on_o |-> !run_o &&
    !write_drive_o) else $error("transfer runs with timing off");
  chk_nem_limit: assert property (pend_q > NEM_CYC + 8 |->
    !timing_on_o) else $error("unanswered request not frozen");
  chk_soft_hold: assert property ($fell(soft_fault_o) |->
    $past(avs_write_i) || $past(init_i) || !timing_on_o)
    else $error("soft fault dropped without a clear");
endmodule // disk_fault_asserts
bind disk_control_fault_status disk_fault_asserts #(.NEM_CYC(NEM_CYC))
  u_chk (.clk_i, .nrst_i, .init_i, .avs_write_i, .bus_request_o,
  .soft_fault_o, .disk_flag_o, .data_flag_o, .intr_o, .intr_level_o,
  .ready_o, .write_drive_o, .run_o, .timing_on_o);

// >>> tb/disk_side_model.sv
// memory slave and disk surface stand-in for the fault bench
`timescale 1ns/10ps
module disk_side_model
  import disk_fault_pkg::*;
(
  input  wire logic     clk_i,         // bench clock
  input  wire logic     nrst_i,        // async reset, low
  input  wire logic     bus_request_i, // memory request from control
  input  wire logic     mute_i,        // high: no slave answers
  output logic          slave_sync_o,  // slave sync to control
  output disk_event_type ev_o          // disk event pulses
);
  logic [1:0] lag_q; // cycles since the request was seen
  initial ev_o = '0;
  // a present slave answers three cycles after a request
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      lag_q        <= 2'h0;
      slave_sync_o <= 1'b0;
    end else if (!bus_request_i || mute_i) begin
      lag_q        <= 2'h0;
      slave_sync_o <= 1'b0; // released sync rests inactive
    end else begin
      lag_q        <= (lag_q == 2'h2) ? lag_q : lag_q + 2'h1;
      slave_sync_o <= (lag_q == 2'h2);
    end
  end
  // bench software stands in for the surface signals
  task automatic pulse(input int b);
    @(posedge clk_i);
    ev_o[b] <= 1'b1;
    @(posedge clk_i);
    ev_o[b] <= 1'b0;
    @(negedge clk_i);
  endtask
endmodule // disk_side_model

// >>> tb/tb_disk_control_fault_status.sv
// self-checking bench for the disk fault and status block
`timescale 1ns/10ps
module tb_disk_control_fault_status
  import disk_fault_pkg::*;
;
  localparam int ABSENT_MEMORY = 20; // short slave sync limit
  localparam logic [4:0] CTL = 5'h00, STA = 5'h04, FLT = 5'h08;
  localparam logic [4:0] PTR = 5'h0C, CNT = 5'h10;
  logic        clk_i = 1'b0, nrst_i = 1'b0, init_i = 1'b0;
  logic        avs_read_i = 1'b0, avs_write_i = 1'b0, mute_q = 1'b0;
  logic        protect_i = 1'b0, advance_i = 1'b0;
  logic [4:0]  avs_address_i = 5'h00;
  logic [31:0] avs_writedata_i = 32'h0000_0000, q, avs_readdata_o;
  logic [3:0]  avs_byteenable_i = 4'hF;
  logic        avs_waitrequest_o, slave_sync_i, bus_request_o, ready_o;
  logic        soft_fault_o, disk_flag_o, data_flag_o, intr_o, run_o;
  logic        write_drive_o, timing_on_o;
  logic [15:0] bus_address_o;
  logic [2:0]  intr_level_o;
  disk_event_type ev_i;
  int          err_count = 0, tests_run = 0, cyc = 0;
  logic [1:0]  fl [3] = '{2'h1, 2'h3, 2'h2}; // write, check, read
  // units 0 and 7 fitted, so both unit faults are reachable
  disk_control_fault_status #(.NEM_CYC(ABSENT_MEMORY), .UNITS_FITTED(8'h81)) dut (
    .clk_i, .nrst_i, .init_i, .avs_address_i, .avs_read_i, .avs_write_i,
    .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o,
    .avs_waitrequest_o, .ev_i, .protect_i, .advance_i, .slave_sync_i,
    .bus_request_o, .bus_address_o, .soft_fault_o, .disk_flag_o,
    .data_flag_o, .intr_o, .intr_level_o, .ready_o, .write_drive_o,
    .run_o, .timing_on_o);
  disk_side_model disk (.clk_i, .nrst_i, .bus_request_i(bus_request_o),
    .mute_i(mute_q), .slave_sync_o(slave_sync_i), .ev_o(ev_i));
  always #4 clk_i = ~clk_i;
  // hang guard: the full run needs a few hundred cycles
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      wrap_up();
    end
  end
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk_reg(input string n, input logic [31:0] e, g);
    tests_run++;
    if (g !== e) begin
      err_count++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chk_bit(input string n, input logic e, g);
    tests_run++;
    if (g !== e) begin
      err_count++;
      $display("BAD %s expected %b seen %b", n, e, g);
    end
  endtask
  // one bus cycle: hold until waitrequest is seen low, data taken there
  task automatic xfer(input logic w, input logic [4:0] a, logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    avs_address_i   <= a;
    avs_writedata_i <= d;
    avs_write_i     <= w;
    avs_read_i      <= !w;
    do begin
      @(negedge clk_i);
      q = avs_readdata_o;
      n++;
    end while (avs_waitrequest_o !== 1'b0 && n < 40);
    if (n == 40) chk_bit("waitrequest", 1'b0, avs_waitrequest_o);
    @(posedge clk_i);
    avs_write_i <= 1'b0;
    avs_read_i  <= 1'b0;
    @(negedge clk_i);
  endtask
  task automatic rdc(input string n, logic [4:0] a, logic [31:0] e, m);
    xfer(1'b0, a, 32'h0000_0000);
    chk_reg(n, e & m, q & m);
  endtask
  task automatic clr();
    xfer(1'b1, CTL, 32'h0000_0100);
  endtask
  initial begin
    repeat (12) @(posedge clk_i);
    nrst_i <= 1'b1;
    rdc("ctrl", CTL, 32'h0000_0080, 32'h0000_FFFF);
    chk_bit("flag", 1'b1, disk_flag_o);
    rdc("unmapped", 5'h14, 32'h0000_0000, 32'hFFFF_FFFF);
    for (int i = 0; i < 3; i++) begin
      xfer(1'b1, CTL, {29'h0, fl[i], 1'b1});
      chk_bit("run", 1'b1, run_o);
      chk_bit("ready", 1'b0, ready_o);
      chk_bit("wdrive", fl[i] == 2'h1, write_drive_o);
      clr();
      chk_bit("ready", 1'b1, ready_o);
    end
    $display("test function done");
    for (int k = 0; k < 3; k++) begin
      clr();
      xfer(1'b1, CTL, 32'h0000_0007);
      disk.pulse(11 - k);
      rdc("soft", STA, 32'h1 << k, 32'h0000_0007);
      chk_bit("softflag", 1'b1, soft_fault_o);
      rdc("sum", CTL, 32'h0000_0200, 32'h0000_0300);
    end
    clr();
    rdc("cleared", STA, 32'h0000_0000, 32'h0000_0FFF);
    @(posedge clk_i);
    protect_i <= 1'b1;
    xfer(1'b1, CTL, 32'h0000_0003);
    disk.pulse(2);
    rdc("protect", STA, 32'h0000_0008, 32'h0000_0008);
    chk_bit("softflag", 1'b1, soft_fault_o);
    @(posedge clk_i);
    protect_i <= 1'b0;
    clr();
    xfer(1'b1, CTL, 32'h0000_0005);
    repeat (2) disk.pulse(0);
    rdc("missed2", STA, 32'h0000_0000, 32'h0000_0010);
    disk.pulse(0);
    rdc("missed3", STA, 32'h0000_0010, 32'h0000_0010);
    clr();
    xfer(1'b1, CTL, 32'h0000_0005);
    repeat (2) disk.pulse(2);
    rdc("late", STA, 32'h0000_0400, 32'h0000_0C00);
    chk_bit("latesoft", 1'b0, soft_fault_o);
    chk_bit("laterun", 1'b1, run_o);
    $display("test soft done");
    clr();
    xfer(1'b1, PTR, 32'h0000_0100);
    xfer(1'b1, CNT, 32'h0000_0002);
    xfer(1'b1, CTL, 32'h0000_0005);
    for (int j = 1; j <= 2; j++) begin
      disk.pulse(2);
      chk_bit("request", 1'b1, data_flag_o);
      chk_reg("busaddr", 32'h100 + 2 * j - 2, bus_address_o);
      repeat (10) @(posedge clk_i);
      disk.pulse(3);
      disk.pulse(1);
      rdc("ptr", PTR, 32'h100 + 2 * j, 32'h0000_FFFF);
      rdc("block", STA, (j - 1) << 9, 32'h0000_0200);
    end
    rdc("count", CNT, 32'h0000_0000, 32'h0000_FFFF);
    clr();
    xfer(1'b1, PTR, 32'h0000_0200);
    xfer(1'b1, CNT, 32'h0000_0001);
    xfer(1'b1, CTL, 32'h0000_0015);
    disk.pulse(2);
    repeat (10) @(posedge clk_i);
    disk.pulse(3);
    rdc("ptrhold", PTR, 32'h0000_0200, 32'h0000_FFFF);
    $display("test transfer done");
    for (int k = 0; k < 5; k++) begin
      clr();
      xfer(1'b1, CTL, 32'h0000_0005);
      disk.pulse(8 - k);
      rdc("hard", FLT, 32'h1 << k, 32'h0000_003F);
      rdc("freeze", CTL, 32'h0000_0300, 32'h0000_0300);
      chk_bit("timing", 1'b0, timing_on_o);
      chk_bit("hardsoft", 1'b0, soft_fault_o);
    end
    clr();
    rdc("hardclr", FLT, 32'h0000_0000, 32'h0000_003F);
    @(posedge clk_i);
    mute_q <= 1'b1;
    xfer(1'b1, CTL, 32'h0000_0005);
    disk.pulse(2);
    repeat (ABSENT_MEMORY + 10) @(posedge clk_i);
    rdc("nomem", FLT, 32'h0000_0020, 32'h0000_0020);
    chk_bit("nemrun", 1'b0, run_o);
    @(posedge clk_i);
    mute_q <= 1'b0;
    $display("test freeze done");
    clr();
    xfer(1'b1, CTL, 32'h0000_1000);
    rdc("absent", STA, 32'h0000_0060, 32'h0000_0060);
    chk_bit("absoft", 1'b1, soft_fault_o);
    xfer(1'b1, CTL, 32'h0000_0000);
    rdc("absclr", STA, 32'h0000_0040, 32'h0000_0060);
    for (int u = 0; u < 2; u++) begin
      clr();
      xfer(1'b1, CTL, u ? 32'h0000_7005 : 32'h0000_0005);
      @(posedge clk_i);
      advance_i <= 1'b1;
      @(posedge clk_i);
      advance_i <= 1'b0;
      @(negedge clk_i);
      rdc("advance", STA, 32'h80 << u, 32'h80 << u);
    end
    clr();
    xfer(1'b1, CTL, 32'h0000_0008);
    chk_bit("intr", 1'b1, intr_o);
    xfer(1'b1, CTL, 32'h0000_0000);
    chk_bit("introff", 1'b0, intr_o);
    // a control write without the low two lanes must be ignored
    @(posedge clk_i);
    avs_byteenable_i <= 4'hC;
    xfer(1'b1, CTL, 32'h0000_0008);
    chk_bit("lanes", 1'b0, intr_o);
    @(posedge clk_i);
    avs_byteenable_i <= 4'hF;
    xfer(1'b1, CTL, 32'h0000_0005);
    disk.pulse(11);
    @(posedge clk_i);
    init_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    init_i <= 1'b0;
    @(negedge clk_i);
    rdc("init", STA, 32'h0000_0000, 32'h0000_0FFF);
    chk_bit("initsoft", 1'b0, soft_fault_o);
    $display("test units done");
    wrap_up();
  end
endmodule // tb_disk_control_fault_status
